//--- pkg/ursb_pkg.sv
// Package: constants, register map and state codes of the status byte block
package ursb_pkg;

   // Register byte offsets on the AHB-Lite slave
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_INT_STAT = 8'h04;
   localparam logic [7:0] OFS_INT_MASK = 8'h08;
   localparam logic [7:0] OFS_ACC_LATCH = 8'h0C;
   localparam logic [7:0] OFS_ACC_MASK = 8'h10;
   localparam logic [7:0] OFS_LAST_BYTE = 8'h14;
   localparam logic [7:0] OFS_STATE = 8'h18;

   // Control register field and reset value
   localparam int CTRL_EN_BIT = 0;
   localparam logic [31:0] CTRL_RST = 32'h0000_0001;

   // Interrupt status bit positions
   localparam int INT_SENT_BIT = 0;
   localparam int INT_LINE_BIT = 1;
   localparam int INT_CMP_BIT = 2;
   localparam int INT_WAKE_BIT = 3;
   localparam int INT_W = 4;
   localparam logic [3:0] INT_MASK_RST = 4'h0;

   // Accessory interrupt latch width and mask reset
   localparam int ACC_W = 4;
   localparam logic [3:0] ACC_MASK_RST = 4'h0;

   // Status byte field positions
   localparam int SB_LINE_LSB = 0;
   localparam int SB_VBUS_LSB = 2;
   localparam int SB_EVT_LSB = 4;
   localparam int SB_ID_BIT = 6;
   localparam int SB_ALT_BIT = 7;

   // Encoded bus voltage levels
   localparam logic [1:0] VB_BELOW_END = 2'h0;
   localparam logic [1:0] VB_END_TO_SESS = 2'h1;
   localparam logic [1:0] VB_SESS_TO_VLD = 2'h2;
   localparam logic [1:0] VB_ABOVE_VLD = 2'h3;

   // Encoded receive events
   localparam logic [1:0] EV_INACTIVE = 2'h0;
   localparam logic [1:0] EV_ACTIVE = 2'h1;
   localparam logic [1:0] EV_ERROR = 2'h3;
   localparam logic [1:0] EV_DISCONNECT = 2'h2;

   // Bus side state machine
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_TURN_UP = 3'b001,
      ST_SEND = 3'b010,
      ST_TURN_DN = 3'b011,
      ST_RX_UP = 3'b100,
      ST_RECV = 3'b101,
      ST_RX_LAST = 3'b110
   } ursb_state_t;

endpackage

//--- rtl/ursb_status_byte.sv
// Receive status byte generator and scheduler with AHB-Lite registers
`timescale 1ns/1ps

// Overview of operation
// - Line state change schedules a status byte.
// - Bus-voltage or ID comparator change schedules a status byte.
// - During receive, status byte sent each cycle with direction high, next low.
// - At start-up, byte sent once direction released and stop low.
// - On leaving asynchronous modes, byte sent once stop low, direction low.
// - Events during transmit wait until stop deasserts at transmit end.
// - Byte carries values sampled when sent, not when triggered.
// - Bytes only in synchronous mode while device drives direction high.
// - Bits 1:0 carry line state, bit 0 D+, bit 1 D-.
// - Bits 3:2 encode bus voltage against the three thresholds.
// - Bits 5:4 encode receive event: inactive, active, error, disconnect.
// - Bit 6 mirrors the identification pin level.
// - Bit 7 set while an unmasked accessory latch bit is set.
// - One idle turnaround cycle on every direction change.
// - All bus transfers on the rising edge of the interface clock.
module ursb_status_byte (
   input wire logic clk,
   input wire logic sys_rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic irq,
   // Analog front end levels
   input wire logic dp_rcv,
   input wire logic dm_rcv,
   input wire logic sess_end,
   input wire logic sess_vld,
   input wire logic vbus_vld,
   input wire logic id_pin,
   // Receiver and transmitter status
   input wire logic rx_active,
   input wire logic rx_error,
   input wire logic host_disc,
   input wire logic rx_byte_valid,
   input wire logic [7:0] rx_byte,
   input wire logic tx_busy,
   input wire logic async_mode,
   input wire logic [ursb_pkg::ACC_W-1:0] acc_evt,
   // Link side bus
   input wire logic ulpi_stp,
   input wire logic [7:0] ulpi_data_i,
   output logic ulpi_dir,
   output logic ulpi_nxt,
   output logic [7:0] ulpi_data_o,
   output logic ulpi_data_oe
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   ursb_pkg::ursb_state_t state_q, state_d;
   logic [31:0] ctrl_q;
   logic [ursb_pkg::INT_W-1:0] int_stat_q, int_mask_q, int_evt;
   logic [ursb_pkg::ACC_W-1:0] acc_latch_q, acc_mask_q;
   logic [7:0] last_byte_q;
   logic pend_q, pend_d, hold_q, wake_q, stp_q, async_q;
   logic [1:0] line_q;
   logic [3:0] cmp_q;
   logic dir_d, nxt_d, oe_d, sent_d;
   logic [7:0] data_d;
   logic [31:0] rd_mux;
   logic dphase_wr_q;
   logic [7:0] dphase_addr_q;

   // Ignored inputs: narrow or read transfers are still whole-word here
   wire unused_ok = &{1'b0, hsize, ulpi_data_i};

   ////////////////////////////////////////////////////////////////////////
   // Status byte assembly, always from present levels

   wire [1:0] line_w = {dm_rcv, dp_rcv};
   wire [3:0] cmp_w = {id_pin, vbus_vld, sess_vld, sess_end};
   wire [1:0] vbus_enc = vbus_vld ? ursb_pkg::VB_ABOVE_VLD :
                         sess_vld ? ursb_pkg::VB_SESS_TO_VLD :
                         sess_end ? ursb_pkg::VB_BELOW_END :
                         ursb_pkg::VB_END_TO_SESS;
   wire [1:0] evt_enc = host_disc ? ursb_pkg::EV_DISCONNECT :
                        !rx_active ? ursb_pkg::EV_INACTIVE :
                        rx_error ? ursb_pkg::EV_ERROR :
                        ursb_pkg::EV_ACTIVE;
   wire alt_int = |(acc_latch_q & acc_mask_q);
   wire [7:0] rxcmd_w = {alt_int, id_pin, evt_enc, vbus_enc, line_w};

   ////////////////////////////////////////////////////////////////////////
   // Trigger detection

   wire line_chg = line_w != line_q;
   wire cmp_chg = cmp_w != cmp_q;
   wire async_exit = async_q && !async_mode;
   // Start-up and mode exit wait for stop low with the bus released
   // Exit cycle skipped, so a pending wake never meets its own re-arm
   wire wake_go = wake_q && !async_mode && !async_q && !ulpi_stp &&
                  state_q == ursb_pkg::ST_IDLE;
   wire trig = line_chg || cmp_chg || wake_go;
   wire en = ctrl_q[ursb_pkg::CTRL_EN_BIT];
   // A held event waits out the whole transmit and its stop pulse
   wire can_send = en && !async_mode && !tx_busy && !hold_q &&
                   !ulpi_stp;

   // Pending merges triggers; a new trigger wins over the clear
   assign sent_d = state_d == ursb_pkg::ST_SEND ||
                   state_d == ursb_pkg::ST_RX_LAST ||
                   (state_d == ursb_pkg::ST_RECV && !rx_byte_valid);
   assign pend_d = trig || (pend_q && !sent_d);

   ////////////////////////////////////////////////////////////////////////
   // Bus state machine

   always_comb begin
      state_d = state_q;
      case (state_q)
         ursb_pkg::ST_IDLE: begin
            if (!async_mode && en && rx_active) begin
               state_d = ursb_pkg::ST_RX_UP;
            end else if (pend_q && can_send) begin
               state_d = ursb_pkg::ST_TURN_UP;
            end
         end
         ursb_pkg::ST_TURN_UP: state_d = ursb_pkg::ST_SEND;
         ursb_pkg::ST_SEND: state_d = ursb_pkg::ST_TURN_DN;
         ursb_pkg::ST_RX_UP: state_d = ursb_pkg::ST_RECV;
         ursb_pkg::ST_RECV: begin
            if (!rx_active) begin
               state_d = ursb_pkg::ST_RX_LAST;
            end
         end
         ursb_pkg::ST_RX_LAST: state_d = ursb_pkg::ST_TURN_DN;
         ursb_pkg::ST_TURN_DN: state_d = ursb_pkg::ST_IDLE;
         default: state_d = ursb_pkg::ST_IDLE;
      endcase
      if (async_mode) begin
         state_d = ursb_pkg::ST_IDLE;
      end
   end

   // Pin values for the next cycle, registered so pins come from flops
   assign dir_d = state_d != ursb_pkg::ST_IDLE &&
                  state_d != ursb_pkg::ST_TURN_DN;
   assign nxt_d = state_d == ursb_pkg::ST_RX_UP ||
                  (state_d == ursb_pkg::ST_RECV && rx_byte_valid);
   assign oe_d = state_d == ursb_pkg::ST_SEND ||
                 state_d == ursb_pkg::ST_RECV ||
                 state_d == ursb_pkg::ST_RX_LAST;
   assign data_d = (state_d == ursb_pkg::ST_RECV && rx_byte_valid) ?
                   rx_byte : (oe_d ? rxcmd_w : 8'h00);

   // All link signals move on the rising edge only
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= ursb_pkg::ST_IDLE;
         ulpi_dir <= 1'b0;
         ulpi_nxt <= 1'b0;
         ulpi_data_oe <= 1'b0;
         ulpi_data_o <= 8'h00;
      end else begin
         state_q <= state_d;
         ulpi_dir <= dir_d;
         ulpi_nxt <= nxt_d;
         ulpi_data_oe <= oe_d;
         ulpi_data_o <= data_d;
      end
   end

   // Trigger bookkeeping; wake starts set so start-up sends a byte
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pend_q <= 1'b0;
         wake_q <= 1'b1;
         hold_q <= 1'b0;
         stp_q <= 1'b0;
         async_q <= 1'b0;
         line_q <= 2'h0;
         cmp_q <= 4'h0;
         last_byte_q <= 8'h00;
      end else begin
         pend_q <= pend_d;
         wake_q <= async_exit || (wake_q && !wake_go);
         hold_q <= tx_busy || (hold_q && !(stp_q && !ulpi_stp));
         stp_q <= ulpi_stp;
         async_q <= async_mode;
         line_q <= line_w;
         cmp_q <= cmp_w;
         if (sent_d) begin
            last_byte_q <= rxcmd_w;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states, always OKAY

   wire take = hsel && htrans[1] && hready;
   wire wr_now = dphase_wr_q;
   wire wr_ctrl = wr_now && dphase_addr_q == ursb_pkg::OFS_CTRL;
   wire wr_stat = wr_now && dphase_addr_q == ursb_pkg::OFS_INT_STAT;
   wire wr_mask = wr_now && dphase_addr_q == ursb_pkg::OFS_INT_MASK;
   wire wr_acc = wr_now && dphase_addr_q == ursb_pkg::OFS_ACC_LATCH;
   wire wr_accm = wr_now && dphase_addr_q == ursb_pkg::OFS_ACC_MASK;
   wire [ursb_pkg::INT_W-1:0] stat_clr = wr_stat ?
                                         hwdata[ursb_pkg::INT_W-1:0] : '0;
   wire [ursb_pkg::ACC_W-1:0] acc_clr = wr_acc ?
                                        hwdata[ursb_pkg::ACC_W-1:0] : '0;

   // Sticky events of this block
   assign int_evt[ursb_pkg::INT_SENT_BIT] = state_d == ursb_pkg::ST_SEND;
   assign int_evt[ursb_pkg::INT_LINE_BIT] = line_chg;
   assign int_evt[ursb_pkg::INT_CMP_BIT] = cmp_chg;
   assign int_evt[ursb_pkg::INT_WAKE_BIT] = wake_go;

   // Read mux; unmapped offsets read zero
   always_comb begin
      case (haddr)
         ursb_pkg::OFS_CTRL: rd_mux = ctrl_q;
         ursb_pkg::OFS_INT_STAT: rd_mux = {28'h0, int_stat_q};
         ursb_pkg::OFS_INT_MASK: rd_mux = {28'h0, int_mask_q};
         ursb_pkg::OFS_ACC_LATCH: rd_mux = {28'h0, acc_latch_q};
         ursb_pkg::OFS_ACC_MASK: rd_mux = {28'h0, acc_mask_q};
         ursb_pkg::OFS_LAST_BYTE: rd_mux = {24'h0, last_byte_q};
         ursb_pkg::OFS_STATE: rd_mux = {26'h0, hold_q, pend_q,
                                       1'b0, state_q};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Address phase capture and read data registered for the data phase
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dphase_wr_q <= 1'b0;
         dphase_addr_q <= 8'h00;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         dphase_wr_q <= take && hwrite;
         dphase_addr_q <= haddr;
         if (take && !hwrite) begin
            hrdata <= rd_mux;
         end
      end
   end

   // Registers; hardware set wins over a write-one clear
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_q <= ursb_pkg::CTRL_RST;
         int_stat_q <= '0;
         int_mask_q <= ursb_pkg::INT_MASK_RST;
         acc_latch_q <= '0;
         acc_mask_q <= ursb_pkg::ACC_MASK_RST;
         irq <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= {31'h0, hwdata[ursb_pkg::CTRL_EN_BIT]};
         end
         if (wr_mask) begin
            int_mask_q <= hwdata[ursb_pkg::INT_W-1:0];
         end
         if (wr_accm) begin
            acc_mask_q <= hwdata[ursb_pkg::ACC_W-1:0];
         end
         int_stat_q <= int_evt | (int_stat_q & ~stat_clr);
         acc_latch_q <= acc_evt | (acc_latch_q & ~acc_clr);
         irq <= |((int_evt | (int_stat_q & ~stat_clr)) & int_mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   own_bus_a: assert property (ulpi_data_oe |-> ulpi_dir)
      else $error("data driven without direction high");
   turn_up_a: assert property ($rose(ulpi_dir) |-> !ulpi_data_oe)
      else $error("no turnaround after direction rise");
   turn_dn_a: assert property ($fell(ulpi_dir)
      |-> !$past(ulpi_data_oe, 2) || $past(ulpi_data_oe))
      else $error("bad direction fall sequence");
   line_pend_a: assert property (line_chg |=> pend_q)
      else $error("line change did not schedule byte");
   cmp_pend_a: assert property (cmp_chg |=> pend_q)
      else $error("comparator change did not schedule byte");
   wake_pend_a: assert property (wake_go |=> pend_q && !wake_q)
      else $error("wake did not schedule byte");
   tx_block_a: assert property ($rose(ulpi_dir) && !ulpi_nxt
      |-> !$past(tx_busy) && !$past(hold_q) && !$past(ulpi_stp))
      else $error("status byte started during transmit");
   serve_a: assert property (pend_q && can_send && !rx_active &&
      state_q == ursb_pkg::ST_IDLE
      |-> ##2 (ulpi_data_oe && !ulpi_nxt || $past(async_mode)))
      else $error("pending byte not sent in two cycles");
   fresh_a: assert property (ulpi_data_oe && !ulpi_nxt
      |-> ulpi_data_o == $past(rxcmd_w))
      else $error("status byte not current");
   line_bits_a: assert property (ulpi_data_oe && !ulpi_nxt
      |-> ulpi_data_o[1:0] == {$past(dm_rcv), $past(dp_rcv)}
      && ulpi_data_o[6] == $past(id_pin))
      else $error("line or id bits wrong");
   recv_cmd_a: assert property (state_q == ursb_pkg::ST_RECV
      && !ulpi_nxt |-> ulpi_data_oe && ulpi_dir)
      else $error("no status byte in receive gap");
   // Field checks rebuild each encoding from the raw levels
   vbus_bits_a: assert property (ulpi_data_oe && !ulpi_nxt
      |-> ulpi_data_o[3] == ($past(vbus_vld) || $past(sess_vld))
      && ulpi_data_o[2] == ($past(vbus_vld) ||
      !$past(sess_vld) && !$past(sess_end)))
      else $error("bus voltage bits wrong");
   evt_bits_a: assert property (ulpi_data_oe && !ulpi_nxt
      |-> ulpi_data_o[5] == ($past(host_disc) ||
      $past(rx_active) && $past(rx_error))
      && ulpi_data_o[4] == (!$past(host_disc) && $past(rx_active)))
      else $error("receive event bits wrong");
   alt_bit_a: assert property (ulpi_data_oe && !ulpi_nxt
      |-> ulpi_data_o[7] == (|($past(acc_latch_q) & $past(acc_mask_q))))
      else $error("alternate interrupt bit wrong");
   rx_start_a: assert property (state_q == ursb_pkg::ST_IDLE
      && rx_active && en && !async_mode
      |=> ulpi_dir && ulpi_nxt && !ulpi_data_oe)
      else $error("receive did not take the bus");
   rx_gap_a: assert property (state_q == ursb_pkg::ST_RECV
      && !rx_byte_valid && !async_mode |=> ulpi_data_oe && !ulpi_nxt)
      else $error("receive gap without status byte");
   async_quiet_a: assert property (async_mode |=> !ulpi_dir)
      else $error("bus held in asynchronous mode");
   turn_gap_a: assert property ($fell(ulpi_dir)
      && !$past(async_mode) |=> !ulpi_dir)
      else $error("direction rose inside turnaround");
   hold_wait_a: assert property (hold_q
      |=> !$rose(ulpi_dir) || ulpi_nxt)
      else $error("held event sent before stop fell");
   line_stat_a: assert property (line_chg
      |=> int_stat_q[ursb_pkg::INT_LINE_BIT])
      else $error("line change not latched");

endmodule // ursb_status_byte

//--- tb/ursb_link_model.sv
// Link side model: stop line, bus idle and status byte capture
`timescale 1ns/1ps
module ursb_link_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic stp_req,
   input wire logic ulpi_dir,
   input wire logic ulpi_nxt,
   input wire logic [7:0] ulpi_data_o,
   input wire logic ulpi_data_oe,
   output logic ulpi_stp,
   output logic [7:0] ulpi_data_i,
   output logic [7:0] sb_byte,
   output int sb_cnt,
   output int bad_cnt
);
   logic dir_q;
   // Stop is only ours while the device has not taken the bus
   assign ulpi_stp = stp_req & ~ulpi_dir;
   // Sample on rising edges only; count drive in turnaround
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dir_q <= 1'b0;
         sb_cnt <= 0;
         bad_cnt <= 0;
         sb_byte <= 8'h00;
         ulpi_data_i <= 8'h00;
      end else begin
         dir_q <= ulpi_dir;
         if (ulpi_data_oe && (ulpi_dir != dir_q || !ulpi_dir)) begin
            bad_cnt <= bad_cnt + 1;
         end
         if (ulpi_dir && dir_q && ulpi_data_oe && !ulpi_nxt) begin
            sb_byte <= ulpi_data_o;
            sb_cnt <= sb_cnt + 1;
         end
         // Bus toggles while direction is high or just fell; a released bus reads zero
         if (ulpi_dir || dir_q) begin
            ulpi_data_i <= ~ulpi_data_i;
         end else begin
            ulpi_data_i <= 8'h00;
         end
      end
   end
endmodule // ursb_link_model

//--- tb/ursb_status_byte_tb.sv
// Self-checking bench of the status byte block
`timescale 1ns/1ps
module ursb_status_byte_tb;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic hsel = 0, hwrite = 0, dp_rcv = 0, dm_rcv = 0, sess_end = 0;
   logic sess_vld = 0, vbus_vld = 0, id_pin = 0, rx_active = 0;
   logic rx_error = 0, host_disc = 0, rx_byte_valid = 0, tx_busy = 0;
   logic async_mode = 0, stp_req = 0, hready, hreadyout, hresp, irq;
   logic ulpi_stp, ulpi_dir, ulpi_nxt, ulpi_data_oe;
   logic [1:0] htrans = 2'h0;
   logic [7:0] haddr = 8'h00, rx_byte = 8'h00;
   logic [7:0] ulpi_data_i, ulpi_data_o, sb_byte;
   logic [3:0] acc_evt = 4'h0;
   logic [31:0] hwdata = 32'h0, hrdata, q, seed;
   int sb_cnt, bad_cnt, n, miscompares = 0, comparisons = 0;
   always #5 clk = ~clk;
   // Slave ready closes the loop as the bus ready
   assign hready = hreadyout;
   ursb_status_byte DUT (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp), .irq(irq), .dp_rcv(dp_rcv), .dm_rcv(dm_rcv),
      .sess_end(sess_end), .sess_vld(sess_vld), .vbus_vld(vbus_vld),
      .id_pin(id_pin), .rx_active(rx_active), .rx_error(rx_error),
      .host_disc(host_disc), .rx_byte_valid(rx_byte_valid),
      .rx_byte(rx_byte), .tx_busy(tx_busy), .async_mode(async_mode),
      .acc_evt(acc_evt), .ulpi_stp(ulpi_stp), .ulpi_data_i(ulpi_data_i),
      .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt), .ulpi_data_o(ulpi_data_o),
      .ulpi_data_oe(ulpi_data_oe));
   ursb_link_model LINK (.clk(clk), .sys_rst(sys_rst), .stp_req(stp_req),
      .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt), .ulpi_data_o(ulpi_data_o),
      .ulpi_data_oe(ulpi_data_oe), .ulpi_stp(ulpi_stp),
      .ulpi_data_i(ulpi_data_i), .sb_byte(sb_byte), .sb_cnt(sb_cnt),
      .bad_cnt(bad_cnt));
   ////////////////////////////////////////////////////////////////////////
   // Expected byte from the levels now at the inputs
   function automatic logic [7:0] exp_sb(input logic alt);
      logic [1:0] vb;
      logic [1:0] ev;
      vb = vbus_vld ? 2'h3 : sess_vld ? 2'h2 : sess_end ? 2'h0 : 2'h1;
      ev = host_disc ? 2'h2 : !rx_active ? 2'h0 : rx_error ? 2'h3 : 2'h1;
      return {alt, id_pin, ev, vb, dm_rcv, dp_rcv};
   endfunction
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic final_report();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_b(input logic got, input logic exp);
      chk_w({31'h0, got}, {31'h0, exp});
   endtask
   // One AHB-Lite single transfer; waits are bounded
   task automatic ahb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do begin
         @(posedge clk);
         k++;
      end while (hready !== 1'b1 && k < 50);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do begin
         @(posedge clk);
         k++;
      end while (hready !== 1'b1 && k < 100);
      q = hrdata;
      if (k >= 100) begin
         miscompares++;
         final_report();
      end
   endtask
   task automatic wait_sb(input int n0);
      int k;
      k = 0;
      while (sb_cnt == n0 && k < 60) begin
         @(posedge clk);
         k++;
      end
      if (sb_cnt == n0) begin
         miscompares++;
         final_report();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      seed = 32'd82934;
      repeat (16) @(posedge clk);
      chk_b(ulpi_dir, 1'b0);
      sys_rst <= 1'b0;
      wait_sb(0);
      chk_w(sb_byte, exp_sb(1'b0));
      ahb(1'b0, ursb_pkg::OFS_CTRL, 32'h0);
      chk_w(q, ursb_pkg::CTRL_RST);
      chk_b(hresp, 1'b0);
      ahb(1'b0, 8'h40, 32'h0);
      chk_w(q, 32'h0);
      ahb(1'b1, ursb_pkg::OFS_INT_MASK, 32'h2);
      // Random line and comparator levels, line always changes
      for (int i = 0; i < 40; i++) begin
         seed = lfsr(seed);
         n = sb_cnt;
         {dm_rcv, sess_end, sess_vld, vbus_vld, id_pin} <= seed[4:0];
         host_disc <= seed[5];
         dp_rcv <= ~dp_rcv;
         wait_sb(n);
         chk_w(sb_byte, exp_sb(1'b0));
         repeat (4) @(posedge clk);
      end
      chk_b(irq, 1'b1);
      ahb(1'b1, ursb_pkg::OFS_INT_STAT, 32'hF);
      repeat (2) @(posedge clk);
      chk_b(irq, 1'b0);
      // Events during transmit merge and wait for stop to fall
      n = sb_cnt;
      tx_busy <= 1'b1;
      @(posedge clk);
      dp_rcv <= ~dp_rcv;
      @(posedge clk);
      id_pin <= ~id_pin;
      repeat (10) @(posedge clk);
      chk_w(sb_cnt, n);
      stp_req <= 1'b1;
      @(posedge clk);
      tx_busy <= 1'b0;
      stp_req <= 1'b0;
      wait_sb(n);
      chk_w(sb_byte, exp_sb(1'b0));
      repeat (10) @(posedge clk);
      chk_w(sb_cnt, n + 1);
      // Asynchronous mode blocks, leaving it sends
      n = sb_cnt;
      async_mode <= 1'b1;
      dm_rcv <= ~dm_rcv;
      repeat (10) @(posedge clk);
      chk_w(sb_cnt, n);
      async_mode <= 1'b0;
      wait_sb(n);
      chk_w(sb_byte, exp_sb(1'b0));
      // The exit owes a byte of its own once the bus is idle again
      n = sb_cnt;
      wait_sb(n);
      chk_w(sb_byte, exp_sb(1'b0));
      // Accessory interrupt flag, read and cleared over AHB-Lite
      ahb(1'b1, ursb_pkg::OFS_ACC_MASK, 32'h1);
      acc_evt <= 4'h1;
      @(posedge clk);
      acc_evt <= 4'h0;
      repeat (8) @(posedge clk);
      n = sb_cnt;
      dp_rcv <= ~dp_rcv;
      wait_sb(n);
      chk_w(sb_byte, exp_sb(1'b1));
      ahb(1'b0, ursb_pkg::OFS_ACC_LATCH, 32'h0);
      chk_w(q, 32'h1);
      ahb(1'b1, ursb_pkg::OFS_ACC_LATCH, 32'h1);
      repeat (8) @(posedge clk);
      n = sb_cnt;
      dp_rcv <= ~dp_rcv;
      wait_sb(n);
      chk_w(sb_byte, exp_sb(1'b0));
      // Receive: status bytes in gaps, active then error
      n = sb_cnt;
      rx_active <= 1'b1;
      // Disconnect outranks receive events, so clear the random level
      host_disc <= 1'b0;
      for (int i = 0; i < 40; i++) begin
         @(posedge clk);
         seed = lfsr(seed);
         if (i % 20 > 3 && ulpi_dir && ulpi_data_oe && !ulpi_nxt) begin
            chk_w(ulpi_data_o[5:4], (i >= 20) ? 2'h3 : 2'h1);
         end
         rx_byte_valid <= seed[0];
         rx_byte <= seed[15:8];
         rx_error <= (i >= 19);
      end
      chk_b(sb_cnt > n, 1'b1);
      rx_active <= 1'b0;
      rx_error <= 1'b0;
      rx_byte_valid <= 1'b0;
      repeat (12) @(posedge clk);
      chk_w(sb_byte, exp_sb(1'b0));
      chk_w(bad_cnt, 0);
      ahb(1'b0, ursb_pkg::OFS_LAST_BYTE, 32'h0);
      chk_w(q, {24'h0, sb_byte});
      final_report();
   end
endmodule // ursb_status_byte_tb
